// >>> rpmc_map.vh
// Purpose: constants for the reset and power mode controller
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   offsets are byte addresses on the register port
`ifndef RPMC_MAP_VH
`define RPMC_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPMC_OFS_GATE1      8'hdb
`define RPMC_OFS_GATE2      8'hdc
`define RPMC_OFS_STATUS     8'hdd
`define RPMC_OFS_CTRL       8'hde

// ----------------------------------------
// reset values, field masks and control bit positions
// ----------------------------------------
`define RPMC_GATE1_RST      8'h00
`define RPMC_GATE2_RST      8'h00
`define RPMC_GATE1_WMASK    8'hef
`define RPMC_CTRL_RST       8'h00
`define RPMC_CTRL_WDT_RST   0
`define RPMC_CTRL_WDT_32K   1

// ----------------------------------------
// gate bit positions in gate register 1
// ----------------------------------------
`define RPMC_G1_PORT_D      7
`define RPMC_G1_PORT_C      6
`define RPMC_G1_PORT_B      5
`define RPMC_G1_SYNC_SER    3
`define RPMC_G1_TWO_WIRE    2
`define RPMC_G1_ASYNC_B     1
`define RPMC_G1_ASYNC_A     0

// ----------------------------------------
// timing
// ----------------------------------------
`define RPMC_RESET_CYCLES   9'd257
`define RPMC_PC_RESET       24'h000000

`endif

// >>> rpmc_top.v
// Purpose: reset merge, reset-mode timer, sleep/halt control and
//          peripheral clock gating
// Assumes: all inputs synchronous to mclk; register port one byte wide
// Notes:   system reset out is registered; sleep stops the system clock
//          reset asserts on the edge after a source rises, never mid-cycle
//          the watchdog wakes halt whatever its reset setting is
//          status and control bytes sit just above the two gate bytes
//          gate register 2 has no known layout, so all eight bits are kept
//          gating a port leaves its alternate pin functions undefined
//
// Decided for this implementation: the address-and-strobe port.

`include "rpmc_map.vh"

module rpmc_top
#(
	parameter ADDR_W = 24
)
(
	// clock and reset
	input  wire              mclk,
	input  wire              srst,
	// reset sources
	input  wire              por_req,
	input  wire              brownout_reset_source,
	input  wire              ext_reset_n,
	input  wire              watchdog_timeout,
	input  wire              rtc_alarm,
	input  wire              debug_reset,
	// cpu side requests and wake events
	input  wire              sleep_instruction,
	input  wire              halt_instruction,
	input  wire              nmi_req,
	input  wire              irq_req,
	input  wire [ADDR_W-1:0] cpu_addr,
	// register port
	input  wire [7:0]        reg_addr,
	input  wire [7:0]        reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	// read data and reset outputs
	output reg  [7:0]        reg_rdata,
	output reg               sys_reset,
	output reg               gpio_force_input,
	output reg  [23:0]       pc_load_value,
	// cpu and clock control
	output reg               cpu_run,
	output reg               osc_enable,
	output reg               sysclk_enable,
	output reg               osc32k_enable,
	output reg               watchdog_32k_clk_en,
	// parked bus
	output reg               bus_park,
	output reg  [ADDR_W-1:0] addr_bus,
	output reg  [7:0]        data_bus,
	output reg               memory_request_strobe,
	output reg  [3:0]        chip_selects,
	output reg               instruction_read_strobe,
	output reg               bus_grant_ack,
	output reg               io_request_strobe,
	output reg               rd_strobe,
	output reg               wr_strobe,
	// peripheral clocks and mode flags
	output reg  [7:0]        periph_clk_en_1,
	output reg  [7:0]        periph_clk_en_2,
	output reg  [7:0]        periph_access_en,
	output reg               sleeping,
	output reg               halted
);

	// ----------------------------------------
	// power mode states
	// ----------------------------------------
	localparam [1:0] ST_RUN   = 2'd0;
	localparam [1:0] ST_HALT  = 2'd1;
	localparam [1:0] ST_SLEEP = 2'd2;

	// mode, timer and register state
	reg  [1:0] mode;
	reg  [1:0] next_mode;
	reg  [8:0] rst_count;
	reg        rst_hold;
	reg  [7:0] gate1;
	reg  [7:0] gate2;
	reg  [7:0] ctrl;
	wire       any_source;
	wire       wdt_reset_req;
	wire       alarm_reset_req;
	wire       in_reset;
	wire       timer_done;
	wire       next_run;
	wire       next_halt;
	wire       next_sleep;
	// reserved bit 4 of gate byte 1 is masked off everywhere
	localparam [7:0] GATE1_WMASK = `RPMC_GATE1_WMASK;

	// ----------------------------------------
	// reset source merge
	// ----------------------------------------
	// watchdog reset qualify
	assign wdt_reset_req   = watchdog_timeout & ctrl[`RPMC_CTRL_WDT_RST];
	assign alarm_reset_req = rtc_alarm & (mode == ST_SLEEP);
	assign any_source = srst | por_req | brownout_reset_source | ~ext_reset_n
		| wdt_reset_req | alarm_reset_req | debug_reset;

	// reset held: a source is live or the stretch is still running
	assign in_reset = any_source | rst_hold;

	// ----------------------------------------
	// reset-mode timer
	// ----------------------------------------
	// the count starts on the first edge with no source left and
	// stops at the terminal value; a new source restarts it from zero
	assign timer_done = (rst_count == `RPMC_RESET_CYCLES - 9'd1);

	always @(posedge mclk)
	begin
		if (any_source)
		begin
			rst_count <= 9'h000;
			rst_hold  <= 1'b1;
		end
		else if (rst_hold)
		begin
			if (timer_done)
				rst_hold <= 1'b0;
			else
				rst_count <= rst_count + 9'd1;
		end
	end

	// ----------------------------------------
	// system reset outputs
	// ----------------------------------------
	// sys_reset rises on the edge after any source goes active and
	// falls two edges after the stretch timer reaches its terminal value
	// asserts on the source cycle edge, releases on count
	// defaults, inputs, pc zero
	// pc load value is a constant, applied by the core while in reset
	always @(posedge mclk)
	begin
		sys_reset        <= in_reset;
		gpio_force_input <= in_reset;
		pc_load_value    <= `RPMC_PC_RESET;
	end

	// ----------------------------------------
	// power mode state machine
	// ----------------------------------------
	// run leaves on a sleep or halt pulse (sleep wins if both);
	// halt leaves on any interrupt or watchdog timeout;
	// sleep is left only when a reset source pulls mode to run
	// next mode from instruction pulses and wake events
	always @*
	begin
		next_mode = mode;
		case (mode)
			ST_RUN:
			begin
				if (sleep_instruction)
					next_mode = ST_SLEEP;
				else if (halt_instruction)
					next_mode = ST_HALT;
			end
			ST_HALT:
			begin
				if (nmi_req | irq_req | watchdog_timeout)
					next_mode = ST_RUN;
			end
			ST_SLEEP:
				next_mode = ST_SLEEP;
			default:
				next_mode = ST_RUN;
		endcase
	end

	// next mode decodes shared by the clock and bus outputs
	assign next_run   = (next_mode == ST_RUN);
	assign next_halt  = (next_mode == ST_HALT);
	assign next_sleep = (next_mode == ST_SLEEP);

	// mode register; a reset always lands in run
	// any reset returns to run via timer
	always @(posedge mclk)
	begin
		if (in_reset)
			mode <= ST_RUN;
		else
			mode <= next_mode;
	end

	// ----------------------------------------
	// clock, cpu and bus control
	// ----------------------------------------
	// clock enables, cpu run and the parked bus, all registered
	// the 32 kHz domain never stops, so alarm and watchdog keep time
	always @(posedge mclk)
	begin
		if (srst)
		begin
			cpu_run                 <= 1'b0;
			osc_enable              <= 1'b1;
			sysclk_enable           <= 1'b1;
			osc32k_enable           <= 1'b1;
			watchdog_32k_clk_en     <= 1'b0;
			bus_park                <= 1'b0;
			addr_bus                <= {ADDR_W{1'b0}};
			data_bus                <= 8'h00;
			memory_request_strobe   <= 1'b1;
			chip_selects            <= 4'hf;
			instruction_read_strobe <= 1'b1;
			bus_grant_ack           <= 1'b1;
			io_request_strobe       <= 1'b1;
			rd_strobe               <= 1'b1;
			wr_strobe               <= 1'b1;
			sleeping                <= 1'b0;
			halted                  <= 1'b0;
		end
		else
		begin
			osc_enable    <= ~next_sleep | any_source;
			sysclk_enable <= ~next_sleep | any_source;
			cpu_run       <= next_run & ~in_reset;
			osc32k_enable       <= 1'b1;
			watchdog_32k_clk_en <= ctrl[`RPMC_CTRL_WDT_32K];
			sleeping      <= next_sleep & ~any_source;
			halted        <= next_halt & ~any_source;
			bus_park      <= ~next_run & ~any_source;
			data_bus      <= 8'h00;
			memory_request_strobe   <= 1'b1;
			chip_selects            <= 4'hf;
			instruction_read_strobe <= 1'b1;
			bus_grant_ack           <= 1'b1;
			io_request_strobe       <= 1'b1;
			rd_strobe               <= 1'b1;
			wr_strobe               <= 1'b1;
			if (mode == ST_RUN)
				addr_bus <= cpu_addr;
		end
	end

	// ----------------------------------------
	// registers and read port
	// ----------------------------------------
	// register map: 0xdb gate byte 1, 0xdc gate byte 2,
	// 0xdd status (read only), 0xde control
	// control bit 0 lets a watchdog timeout reset the system,
	// control bit 1 moves the watchdog onto the 32 kHz clock
	// software writes; dropped while the system is held in reset
	// reset enables all clocks
	always @(posedge mclk)
	begin
		if (sys_reset)
		begin
			gate1 <= `RPMC_GATE1_RST;
			gate2 <= `RPMC_GATE2_RST;
			ctrl  <= `RPMC_CTRL_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `RPMC_OFS_GATE1)
				gate1 <= reg_wdata & `RPMC_GATE1_WMASK;
			if (reg_addr == `RPMC_OFS_GATE2)
				gate2 <= reg_wdata;
			if (reg_addr == `RPMC_OFS_CTRL)
				ctrl <= reg_wdata & 8'h03;
		end
	end

	// read data for one cycle after the strobe, zero otherwise
	always @(posedge mclk)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`RPMC_OFS_GATE1:  reg_rdata <= gate1;
				`RPMC_OFS_GATE2:  reg_rdata <= gate2;
				`RPMC_OFS_STATUS: reg_rdata <= {5'h00, rst_hold, halted, sleeping};
				`RPMC_OFS_CTRL:   reg_rdata <= ctrl;
				default:          reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ----------------------------------------
	// peripheral clock gates
	// ----------------------------------------
	// one bit gates clock
	// port gates also cut register access
	// per-bit gates: a one in a gate byte stops that clock; in gate byte 1
	// it also closes the peripheral's register access; masked bits stay on
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_gate
			always @(posedge mclk)
			begin
				periph_clk_en_1[gi]  <= ~gate1[gi] | ~GATE1_WMASK[gi];
				periph_clk_en_2[gi]  <= ~gate2[gi];
				periph_access_en[gi] <= ~gate1[gi] | ~GATE1_WMASK[gi];
			end
		end
	endgenerate

endmodule

// >>> rpmc_sva.sv
// Purpose: assertions on the reset and power mode ports
// Assumes: one mclk domain, srst synchronous
// Notes:   bound to every rpmc_top instance
module rpmc_sva
#(
	parameter ADDR_W = 24
)
(
	input wire logic mclk, srst, por_req, brownout_reset_source, ext_reset_n,
	input wire logic watchdog_timeout, rtc_alarm, debug_reset, nmi_req, irq_req,
	input wire logic sys_reset, gpio_force_input, cpu_run, osc_enable, sysclk_enable,
	input wire logic bus_park, sleeping, halted, memory_request_strobe,
	input wire logic instruction_read_strobe, bus_grant_ack, io_request_strobe,
	input wire logic rd_strobe, wr_strobe,
	input wire logic [3:0] chip_selects,
	input wire logic [7:0] data_bus,
	input wire logic [23:0] pc_load_value,
	input wire logic [ADDR_W-1:0] addr_bus
);
	wire src = srst | por_req | brownout_reset_source | ~ext_reset_n | debug_reset | watchdog_timeout | rtc_alarm;
	logic [9:0] cnt;
	// quiet edges seen while still in reset
	always @(posedge mclk)
	begin
		if (src)
			cnt <= 10'h000;
		else if (sys_reset)
			cnt <= cnt + 10'h001;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_src_merge: assert property ((por_req | brownout_reset_source | ~ext_reset_n | debug_reset) |=> sys_reset)
		else $error("reset source ignored");
	a_alarm_sleep: assert property (sleeping && rtc_alarm |=> sys_reset)
		else $error("alarm in sleep did not reset");
	a_reset_len: assert property ($fell(sys_reset) |-> cnt == 10'd258)
		else $error("reset stretch length wrong");
	a_reset_outs: assert property (sys_reset |-> gpio_force_input && pc_load_value == 24'h000000 && !cpu_run)
		else $error("reset outputs wrong");
	a_sleep_stop: assert property (sleeping |-> !osc_enable && !sysclk_enable && !cpu_run && bus_park)
		else $error("sleep left clocks running");
	a_sleep_exit: assert property (sleeping && !src |=> sleeping)
		else $error("sleep left without reset");
	a_addr_hold: assert property ((sleeping | halted) && $past(sleeping | halted) |-> $stable(addr_bus))
		else $error("address moved while idle");
	a_bus_park: assert property ((sleeping | halted) |-> data_bus == 8'h00 && (&{memory_request_strobe,
		chip_selects, instruction_read_strobe, bus_grant_ack, io_request_strobe, rd_strobe, wr_strobe}))
		else $error("bus not parked");
	a_halt_clk: assert property (halted |-> osc_enable && sysclk_enable && !cpu_run)
		else $error("halt stopped clocks");
	a_halt_wake: assert property (halted && (nmi_req | irq_req | watchdog_timeout) |=> !halted)
		else $error("halt not left on wake event");
	c_sleep: cover property ($rose(sleeping));
	c_halt: cover property ($rose(halted));
	c_release: cover property ($fell(sys_reset));
endmodule
bind rpmc_top rpmc_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// >>> rpmc_cpu_model.sv
// Purpose: cpu core stand-in giving address and mode requests
// Assumes: drives right after rising mclk
// Notes:   address advances only while the core runs
module rpmc_cpu_model
(
	input  wire logic        mclk,
	input  wire logic        cpu_run,
	output logic      [23:0] cpu_addr,
	output logic             sleep_instruction,
	output logic             halt_instruction
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		cpu_addr = 24'h000000;
		{halt_instruction, sleep_instruction} = 2'b00;
	end
	// fetch address moves each running cycle
	always @(posedge mclk)
	begin
		if (cpu_run)
			cpu_addr <= cpu_addr + 24'h000001;
	end
	// one-cycle instruction pulse: 0 sleep, 1 halt
	task op(input int k);
	begin
		@(posedge mclk);
		{halt_instruction, sleep_instruction} <= k ? 2'b10 : 2'b01;
		@(posedge mclk);
		{halt_instruction, sleep_instruction} <= 2'b00;
	end
	endtask
endmodule

// >>> rpmc_top_tb_top.sv
// Purpose: self-checking bench for rpmc_top
// Assumes: 20 MHz mclk, register port with one-cycle read data
// Notes:   stretch counts taken 1 ns after each edge
module rpmc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, srst = 1, por_req = 1, brownout_reset_source = 0, ext_reset_n = 1;
	logic watchdog_timeout = 0, rtc_alarm = 0, debug_reset = 0, nmi_req = 0, irq_req = 0;
	logic reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire sleep_instruction, halt_instruction, sys_reset, gpio_force_input, cpu_run, osc_enable;
	wire sysclk_enable, osc32k_enable, watchdog_32k_clk_en, bus_park, memory_request_strobe;
	wire instruction_read_strobe, bus_grant_ack, io_request_strobe, rd_strobe, wr_strobe, sleeping, halted;
	wire [3:0] chip_selects;
	wire [7:0] reg_rdata, data_bus, periph_clk_en_1, periph_clk_en_2, periph_access_en;
	wire [23:0] cpu_addr, pc_load_value, addr_bus;
	int err_count = 0, checked = 0, n;
	rpmc_top dut (.*);
	rpmc_cpu_model u_cpu (.*);
	// clock source
	always #25 mclk = ~mclk;
	task chk(input logic [15:0] g, e);
	begin
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task wr(input logic [7:0] a, d);
	begin
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	end
	endtask
	task rd(input logic [7:0] a, e);
	begin
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	end
	endtask
	// edges until system reset drops, bounded
	task relwait;
	begin
		n = 0;
		while (sys_reset === 1'b1 && n < 400)
		begin
			@(posedge mclk);
			#1 n++;
		end
	end
	endtask
	task conclude;
	begin
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// hang guard
	initial
	begin
		#250000;
		err_count++;
		conclude;
	end
	// ----
	// test sequence
	// ----
	initial
	begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		por_req <= 1'b0;
		relwait;
		chk(n[15:0], 16'd258);
		rd(8'hdb, 8'h00);
		chk(periph_clk_en_1, 8'hff);
		wr(8'hdb, 8'hff);
		rd(8'hdb, 8'hef);
		chk(periph_clk_en_1, 8'h10);
		chk(periph_access_en, 8'h10);
		wr(8'hdc, 8'ha5);
		rd(8'hdc, 8'ha5);
		chk(periph_clk_en_2, 8'h5a);
		rd(8'hd0, 8'h00);
		$display("test registers done");
		for (int k = 0; k < 3; k++)
		begin
			wr(8'hdb, 8'hef);
			rd(8'hdb, 8'hef);
			u_cpu.op(1);
			@(posedge mclk);
			#1 chk(halted, 1'b1);
			rd(8'hdd, 8'h02);
			@(posedge mclk);
			{nmi_req, irq_req, watchdog_timeout} <= 3'b100 >> k;
			@(posedge mclk);
			{nmi_req, irq_req, watchdog_timeout} <= 3'b000;
			#1 chk(halted, 1'b0);
			chk(sys_reset, 1'b0);
		end
		$display("test halt done");
		u_cpu.op(0);
		@(posedge mclk);
		#1 chk(sleeping, 1'b1);
		chk(osc32k_enable, 1'b1);
		@(posedge mclk);
		rtc_alarm <= 1'b1;
		@(posedge mclk);
		rtc_alarm <= 1'b0;
		#1 chk(sys_reset, 1'b1);
		relwait;
		chk(n[15:0], 16'd258);
		chk(sleeping, 1'b0);
		rd(8'hdb, 8'h00);
		$display("test sleep done");
		for (int k = 0; k < 3; k++)
		begin
			@(posedge mclk);
			{brownout_reset_source, debug_reset, ext_reset_n} <= 3'b001 ^ (3'b100 >> k);
			repeat (300) @(posedge mclk);
			#1 chk(sys_reset, 1'b1);
			@(posedge mclk);
			{brownout_reset_source, debug_reset, ext_reset_n} <= 3'b001;
			relwait;
			chk(n[15:0], 16'd258);
		end
		$display("test sources done");
		wr(8'hde, 8'h03);
		rd(8'hde, 8'h03);
		chk(watchdog_32k_clk_en, 1'b1);
		@(posedge mclk);
		watchdog_timeout <= 1'b1;
		@(posedge mclk);
		watchdog_timeout <= 1'b0;
		#1 chk(sys_reset, 1'b1);
		relwait;
		chk(n[15:0], 16'd258);
		rd(8'hde, 8'h00);
		chk(watchdog_32k_clk_en, 1'b0);
		$display("test watchdog done");
		conclude;
	end
endmodule
